// File: exec_pkg.sv
// package: opcodes, field positions, reset values and timing counts for the instruction subset executor
package exec_pkg;
    localparam int          INSTR_W       = 12;
    localparam int          DATA_W        = 8;
    localparam int          FADDR_W       = 5;
    localparam int          BANK_W        = 3;
    localparam int          PC_W          = 11;
    localparam int          FILE_DEPTH    = 32;
    // field positions inside the 12-bit instruction word
    localparam int          DEST_BIT      = 5;
    localparam int          FADDR_LSB     = 0;
    localparam int          LIT_LSB       = 0;
    // opcode patterns, compared after masking
    localparam logic [11:0] OPC_NO_OP      = 12'h000;
    localparam logic [11:0] OPC_OPTION     = 12'h002;
    localparam logic [11:0] OPC_SLEEP      = 12'h003;
    localparam logic [11:0] OPC_LOAD_BANK  = 12'h010;
    localparam logic [11:0] OPC_STORE_ACC  = 12'h020;
    localparam logic [11:0] OPC_OR_FILE    = 12'h100;
    localparam logic [11:0] OPC_MOVE_FILE  = 12'h200;
    localparam logic [11:0] OPC_INC_FILE   = 12'h280;
    localparam logic [11:0] OPC_INC_SKIP   = 12'h3c0;
    localparam logic [11:0] OPC_RETURN_LIT = 12'h800;
    localparam logic [11:0] OPC_OR_LIT     = 12'hd00;
    localparam logic [11:0] OPC_LOAD_LIT   = 12'hc00;
    localparam logic [11:0] MASK_FULL     = 12'hfff;
    localparam logic [11:0] MASK_BANK     = 12'hff8;
    localparam logic [11:0] MASK_FSTORE   = 12'hfe0;
    localparam logic [11:0] MASK_FDEST    = 12'hfc0;
    localparam logic [11:0] MASK_LIT      = 12'hf00;
    // reset values
    localparam logic [7:0]  ACC_RST       = 8'h00;
    localparam logic [7:0]  FILE_RST      = 8'h00;
    localparam logic [7:0]  CFG_RST       = 8'hff;
    localparam logic [2:0]  BANK_RST      = 3'h0;
    localparam logic [7:0]  WDOG_CLEAR    = 8'h00;
    // timing: instruction cycle counts
    localparam int          CYC_SINGLE    = 1;
    localparam int          CYC_BRANCH    = 2;
    localparam logic [1:0]  FLUSH_CYCLES  = 2'(CYC_BRANCH - CYC_SINGLE);

    typedef enum logic [3:0] {
        OP_NO_OP,
        OP_INC_FILE,
        OP_INC_SKIP,
        OP_OR_LIT,
        OP_OR_FILE,
        OP_STORE_ACC,
        OP_MOVE_FILE,
        OP_LOAD_BANK,
        OP_OPTION,
        OP_LOAD_LIT,
        OP_RETURN_LIT,
        OP_SLEEP,
        OP_ILLEGAL
    } op_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_FLUSH,
        ST_SLEEP
    } exec_state_t;
endpackage

// File: instr_decode.sv
// instruction classifier: maps a 12-bit word to an operation code
`timescale 1ns/10ps
module instr_decode
    import exec_pkg::*;
(
    // instruction word
    input  wire logic [exec_pkg::INSTR_W-1:0] instr_i,
    // decoded operation
    output op_t                               op_o
);
    import exec_pkg::*;

    function automatic logic hit(input logic [11:0] w, input logic [11:0] m, input logic [11:0] p);
        hit = ((w & m) == p);
    endfunction

    always_comb
    begin
        if (hit(instr_i, MASK_FULL, OPC_NO_OP))
            op_o = OP_NO_OP;
        else if (hit(instr_i, MASK_FULL, OPC_OPTION))
            op_o = OP_OPTION;
        else if (hit(instr_i, MASK_FULL, OPC_SLEEP))
            op_o = OP_SLEEP;
        else if (hit(instr_i, MASK_BANK, OPC_LOAD_BANK))
            op_o = OP_LOAD_BANK;
        else if (hit(instr_i, MASK_FSTORE, OPC_STORE_ACC))
            op_o = OP_STORE_ACC;
        else if (hit(instr_i, MASK_FDEST, OPC_OR_FILE))
            op_o = OP_OR_FILE;
        else if (hit(instr_i, MASK_FDEST, OPC_MOVE_FILE))
            op_o = OP_MOVE_FILE;
        else if (hit(instr_i, MASK_FDEST, OPC_INC_FILE))
            op_o = OP_INC_FILE;
        else if (hit(instr_i, MASK_FDEST, OPC_INC_SKIP))
            op_o = OP_INC_SKIP;
        else if (hit(instr_i, MASK_LIT, OPC_RETURN_LIT))
            op_o = OP_RETURN_LIT;
        else if (hit(instr_i, MASK_LIT, OPC_OR_LIT))
            op_o = OP_OR_LIT;
        else if (hit(instr_i, MASK_LIT, OPC_LOAD_LIT))
            op_o = OP_LOAD_LIT;
        else
            op_o = OP_ILLEGAL;
    end
endmodule

// File: subset_exec.sv
// executor for a twelve-instruction subset of an 8-bit core, with file registers and status
// How it works
// - increment_file adds one to file f, result to destination, updates null flag
// - destination bit 0 writes the accumulator, 1 writes back into file f
// - increment_skip_zero leaves flags; a zero result flushes next fetch as one no-op
// - or_literal_acc ORs accumulator with 8-bit literal, result to accumulator, null flag
// - or_acc_file ORs accumulator with file f to destination, updates null flag
// - store_acc_to_file copies accumulator into file f, flags unchanged
// - move_file copies file f to the chosen destination, always updating null flag
// - move_file with destination 1 rewrites f with itself, acting as a zero test
// - load_bank_literal writes 3-bit literal into bank_select_register, flags unchanged
// - configuration load copies accumulator into timer configuration, no flags touched
// - load_literal_acc puts 8-bit literal into accumulator, flags unchanged
// - return_with_literal loads accumulator, pops stack_top into pc, two cycles
// - sleep clears watchdog_counter and its prescaler
// - sleep sets expiry_status_bit, clears powerdown_status_bit, keeps pin_change_wake_flag
// - after sleep the core halts with its oscillator stopped
`timescale 1ns/10ps
module subset_exec
    import exec_pkg::*;
(
    // clock and reset
    input  wire logic                         mclk_i,
    input  wire logic                         rst_i,
    // fetch path
    input  wire logic                         instr_valid_i,
    input  wire logic [exec_pkg::INSTR_W-1:0] instr_i,
    input  wire logic [exec_pkg::PC_W-1:0]    stack_top_i,
    output logic                              stack_pop_o,
    output logic      [exec_pkg::PC_W-1:0]    pc_o,
    output logic                              flush_o,
    // wake from sleep
    input  wire logic                         wake_i,
    input  wire logic                         pin_change_wake_flag_i,
    // state seen by the rest of the core
    output logic      [exec_pkg::DATA_W-1:0]  acc_o,
    output logic      [exec_pkg::BANK_W-1:0]  bank_select_register_o,
    output logic      [exec_pkg::DATA_W-1:0]  timer_cfg_o,
    output logic                              null_flag_o,
    output logic                              expiry_status_bit_o,
    output logic                              powerdown_status_bit_o,
    output logic                              pin_change_wake_flag_o,
    // watchdog and power control
    output logic                              watchdog_clear_o,
    output logic                              prescaler_clear_o,
    output logic                              osc_stop_o,
    output logic                              sleeping_o,
    // file register debug read port
    input  wire logic [exec_pkg::FADDR_W-1:0] dbg_addr_i,
    output logic      [exec_pkg::DATA_W-1:0]  dbg_data_o
);
    import exec_pkg::*;

    op_t                       op;
    exec_state_t               state_q, state_d;
    logic [DATA_W-1:0]         file_q [FILE_DEPTH];
    logic [DATA_W-1:0]         acc_q, acc_d;
    logic [BANK_W-1:0]         bank_q, bank_d;
    logic [DATA_W-1:0]         cfg_q, cfg_d;
    logic                      null_q, null_d;
    logic                      expiry_q, expiry_d;
    logic                      pdown_q, pdown_d;
    logic [PC_W-1:0]           pc_q, pc_d;
    logic                      file_we;
    logic [DATA_W-1:0]         file_wdata;
    logic [FADDR_W-1:0]        faddr;
    logic [DATA_W-1:0]         fval;
    logic [DATA_W-1:0]         lit;
    logic                      dest_file;
    logic [DATA_W-1:0]         result;
    logic                      exec_en;

    instr_decode u_decode
    (
        .instr_i (instr_i),
        .op_o    (op)
    );

    assign faddr     = instr_i[FADDR_LSB +: FADDR_W];
    assign lit       = instr_i[LIT_LSB +: DATA_W];
    assign dest_file = instr_i[DEST_BIT];
    assign fval      = file_q[faddr];
    // an instruction only executes when running; the flushed slot is a forced no-op
    assign exec_en   = instr_valid_i && (state_q == ST_RUN);

    always_comb
    begin
        state_d     = state_q;
        acc_d       = acc_q;
        bank_d      = bank_q;
        cfg_d       = cfg_q;
        null_d      = null_q;
        expiry_d    = expiry_q;
        pdown_d     = pdown_q;
        pc_d        = pc_q;
        file_we     = 1'b0;
        file_wdata  = fval;
        result      = fval;
        stack_pop_o       = 1'b0;
        flush_o           = 1'b0;
        watchdog_clear_o  = 1'b0;
        prescaler_clear_o = 1'b0;
        case (state_q)
            ST_RUN:
            begin
                if (exec_en)
                begin
                    pc_d = pc_q + PC_W'(CYC_SINGLE);
                    case (op)
                        OP_INC_FILE, OP_INC_SKIP, OP_OR_FILE, OP_MOVE_FILE:
                        begin
                            if (op == OP_OR_FILE)
                                result = acc_q | fval;
                            else if (op == OP_MOVE_FILE)
                                result = fval;
                            else
                                result = fval + 8'h01;
                            if (dest_file)
                            begin
                                file_we    = 1'b1;
                                file_wdata = result;
                            end
                            else
                                acc_d = result;
                            if (op != OP_INC_SKIP)
                                null_d = (result == 8'h00);
                            else if (result == 8'h00)
                            begin
                                state_d = ST_FLUSH;
                                flush_o = 1'b1;
                            end
                        end
                        OP_OR_LIT:
                        begin
                            acc_d  = acc_q | lit;
                            null_d = ((acc_q | lit) == 8'h00);
                        end
                        OP_STORE_ACC:
                        begin
                            file_we    = 1'b1;
                            file_wdata = acc_q;
                        end
                        OP_LOAD_BANK:
                            bank_d = lit[BANK_W-1:0];
                        OP_OPTION:
                            cfg_d = acc_q;
                        OP_LOAD_LIT:
                            acc_d = lit;
                        OP_RETURN_LIT:
                        begin
                            acc_d       = lit;
                            pc_d        = stack_top_i;
                            stack_pop_o = 1'b1;
                            flush_o     = 1'b1;
                            state_d     = ST_FLUSH;
                        end
                        OP_SLEEP:
                        begin
                            watchdog_clear_o  = 1'b1;
                            prescaler_clear_o = 1'b1;
                            expiry_d          = 1'b1;
                            pdown_d           = 1'b0;
                            state_d           = ST_SLEEP;
                        end
                        default:
                        begin
                            // no_operation and unknown words only advance pc
                        end
                    endcase
                end
            end
            ST_FLUSH:
            begin
                // discarded fetch: one extra cycle with nothing written
                if (instr_valid_i)
                begin
                    pc_d    = pc_q + PC_W'(CYC_SINGLE);
                    state_d = ST_RUN;
                end
            end
            ST_SLEEP:
            begin
                if (wake_i)
                    state_d = ST_RUN;
            end
            default:
                state_d = ST_RUN;
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q  <= ST_RUN;
            acc_q    <= ACC_RST;
            bank_q   <= BANK_RST;
            cfg_q    <= CFG_RST;
            null_q   <= 1'b0;
            expiry_q <= 1'b1;
            pdown_q  <= 1'b1;
            pc_q     <= '0;
        end
        else
        begin
            state_q  <= state_d;
            acc_q    <= acc_d;
            bank_q   <= bank_d;
            cfg_q    <= cfg_d;
            null_q   <= null_d;
            expiry_q <= expiry_d;
            pdown_q  <= pdown_d;
            pc_q     <= pc_d;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < FILE_DEPTH; gi++)
        begin : g_file
            always_ff @(posedge mclk_i or posedge rst_i)
            begin
                if (rst_i)
                    file_q[gi] <= FILE_RST;
                else if (file_we && (faddr == FADDR_W'(gi)))
                    file_q[gi] <= file_wdata;
            end
        end
    endgenerate

    assign acc_o                  = acc_q;
    assign bank_select_register_o = bank_q;
    assign timer_cfg_o            = cfg_q;
    assign null_flag_o            = null_q;
    assign expiry_status_bit_o    = expiry_q;
    assign powerdown_status_bit_o = pdown_q;
    // wake flag passes through untouched by sleep
    assign pin_change_wake_flag_o = pin_change_wake_flag_i;
    assign pc_o                   = pc_q;
    assign sleeping_o             = (state_q == ST_SLEEP);
    assign osc_stop_o             = (state_q == ST_SLEEP);
    assign dbg_data_o             = file_q[dbg_addr_i];
endmodule

// File: subset_exec_chk.sv
// port-level assertion checker for the instruction subset executor
`timescale 1ns/10ps
module subset_exec_chk
    import exec_pkg::*;
(
    // clock and reset
    input wire logic        mclk_i,
    input wire logic        rst_i,
    // fetch path
    input wire logic        instr_valid_i,
    input wire logic [11:0] instr_i,
    input wire logic [10:0] stack_top_i,
    input wire logic        stack_pop_o,
    input wire logic [10:0] pc_o,
    input wire logic        flush_o,
    // state, status and power
    input wire logic        wake_i,
    input wire logic        pin_change_wake_flag_i,
    input wire logic [7:0]  acc_o,
    input wire logic        null_flag_o,
    input wire logic        expiry_status_bit_o,
    input wire logic        powerdown_status_bit_o,
    input wire logic        pin_change_wake_flag_o,
    input wire logic        watchdog_clear_o,
    input wire logic        prescaler_clear_o,
    input wire logic        osc_stop_o,
    input wire logic        sleeping_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    // the word after a flush is dropped, so it must not count as executed
    logic skip_q;
    logic skip_d;
    logic ex;
    always_comb
    begin
        skip_d = flush_o ? 1'b1 : (instr_valid_i ? 1'b0 : skip_q);
    end
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            skip_q <= 1'b0;
        else
            skip_q <= skip_d;
    end
    assign ex = instr_valid_i && !skip_q && !sleeping_o;
    wdog_clear_a: assert property (ex && instr_i == OPC_SLEEP |-> watchdog_clear_o && prescaler_clear_o)
        else $error("sleep did not clear watchdog");
    sleep_status_a: assert property (ex && instr_i == OPC_SLEEP |=> expiry_status_bit_o && !powerdown_status_bit_o)
        else $error("sleep status bits wrong");
    sleep_hold_a: assert property (sleeping_o && !wake_i |=> sleeping_o && osc_stop_o && $stable(pc_o))
        else $error("sleep state left without wake");
    wake_flag_a: assert property (pin_change_wake_flag_o == pin_change_wake_flag_i)
        else $error("wake flag altered");
    ret_pop_a: assert property (ex && instr_i[11:8] == 4'h8 |-> stack_pop_o && flush_o ##1 pc_o == $past(stack_top_i))
        else $error("return did not pop stack");
    lit_load_a: assert property (ex && instr_i[11:8] == 4'hc |=> acc_o == $past(instr_i[7:0]) && $stable(null_flag_o))
        else $error("literal load wrong");
    or_lit_a: assert property (ex && instr_i[11:8] == 4'hd |=> acc_o == ($past(acc_o) | $past(instr_i[7:0]))
        && null_flag_o == (acc_o == 8'h00))
        else $error("literal or wrong");
    pc_step_a: assert property (instr_valid_i && !sleeping_o && !stack_pop_o |=> pc_o == 11'($past(pc_o) + 11'h001))
        else $error("pc did not advance by one");
    skip_hold_a: assert property (instr_valid_i && skip_q && !sleeping_o |=> $stable(acc_o) && $stable(null_flag_o))
        else $error("dropped word changed state");
endmodule

bind subset_exec subset_exec_chk i_chk (
    .mclk_i, .rst_i, .instr_valid_i, .instr_i, .stack_top_i, .stack_pop_o, .pc_o, .flush_o, .wake_i,
    .pin_change_wake_flag_i, .acc_o, .null_flag_o, .expiry_status_bit_o, .powerdown_status_bit_o,
    .pin_change_wake_flag_o, .watchdog_clear_o, .prescaler_clear_o, .osc_stop_o, .sleeping_o
);

// File: subset_exec_tb_top.sv
// self-checking bench for the instruction subset executor
`timescale 1ns/10ps
module subset_exec_tb_top;
    import exec_pkg::*;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        instr_valid_i = 1'b0;
    logic [11:0] instr_i = 12'h000;
    logic [10:0] stack_top_i = 11'h000;
    logic        wake_i = 1'b0;
    logic        pin_change_wake_flag_i = 1'b0;
    logic [4:0]  dbg_addr_i = 5'h00;
    logic        stack_pop_o, flush_o, null_flag_o, expiry_status_bit_o, powerdown_status_bit_o;
    logic        pin_change_wake_flag_o, watchdog_clear_o, prescaler_clear_o, osc_stop_o, sleeping_o;
    logic [10:0] pc_o;
    logic [7:0]  acc_o, timer_cfg_o, dbg_data_o;
    logic [2:0]  bank_select_register_o;
    logic [41:0] obs;
    logic [41:0] notes [$];
    logic [7:0]  acc_m, cfg_m;
    logic [7:0]  rf [32];
    logic [2:0]  bank_m;
    logic [10:0] pc_m;
    logic        z_m, exp_m, pd_m, sl_m, skip_m;
    int          num_errors = 0;
    int          n_compared = 0;
    logic [11:0] bases [11] = '{OPC_NO_OP, OPC_OPTION, OPC_LOAD_BANK, OPC_STORE_ACC, OPC_OR_FILE, OPC_MOVE_FILE,
                                OPC_INC_FILE, OPC_INC_SKIP, OPC_RETURN_LIT, OPC_LOAD_LIT, OPC_OR_LIT};
    logic [11:0] masks [11] = '{MASK_FULL, MASK_FULL, MASK_BANK, MASK_FSTORE, MASK_FDEST, MASK_FDEST, MASK_FDEST,
                                MASK_FDEST, MASK_LIT, MASK_LIT, MASK_LIT};

    subset_exec i_dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .stack_top_i(stack_top_i), .stack_pop_o(stack_pop_o), .pc_o(pc_o), .flush_o(flush_o),
        .wake_i(wake_i), .pin_change_wake_flag_i(pin_change_wake_flag_i), .acc_o(acc_o),
        .bank_select_register_o(bank_select_register_o), .timer_cfg_o(timer_cfg_o), .null_flag_o(null_flag_o),
        .expiry_status_bit_o(expiry_status_bit_o), .powerdown_status_bit_o(powerdown_status_bit_o),
        .pin_change_wake_flag_o(pin_change_wake_flag_o), .watchdog_clear_o(watchdog_clear_o),
        .prescaler_clear_o(prescaler_clear_o), .osc_stop_o(osc_stop_o), .sleeping_o(sleeping_o),
        .dbg_addr_i(dbg_addr_i), .dbg_data_o(dbg_data_o)
    );

    assign obs = {pc_o, acc_o, null_flag_o, dbg_data_o, bank_select_register_o, timer_cfg_o,
                  expiry_status_bit_o, powerdown_status_bit_o, sleeping_o};

    initial
    begin
        forever #12.5 mclk_i = ~mclk_i;
    end

    task automatic check(input logic [41:0] seen, input logic [41:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic mreset();
        // let the last pending note be compared before reset disturbs the outputs
        @(negedge mclk_i);
        #2;
        rst_i = 1'b1;
        {acc_m, z_m, bank_m, cfg_m, exp_m, pd_m, pc_m} = {ACC_RST, 1'b0, BANK_RST, CFG_RST, 1'b1, 1'b1, 11'h000};
        {sl_m, skip_m} = 2'b00;
        foreach (rf[i]) rf[i] = FILE_RST;
        repeat (3) @(posedge mclk_i);
        #2;
        rst_i = 1'b0;
    endtask

    // reference behaviour; the note is taken after the executing edge
    task automatic issue(input logic [11:0] w);
        logic [7:0] f;
        logic [7:0] r;
        logic       wr;
        f = rf[w[4:0]];
        {wr, r} = 9'h000;
        stack_top_i = 11'($urandom);
        pin_change_wake_flag_i = 1'($urandom);
        instr_valid_i = 1'b1;
        instr_i = w;
        if (!sl_m)
            pc_m = pc_m + 11'h001;
        if (!sl_m && skip_m)
            skip_m = 1'b0;
        else if (!sl_m)
        begin
            casez (w)
                12'h002: cfg_m = acc_m;
                12'h003: {sl_m, exp_m, pd_m} = 3'b110;
                12'b0000_0001_0???: bank_m = w[2:0];
                12'b0000_001?_????: rf[w[4:0]] = acc_m;
                12'b0001_00??_????: {wr, r} = {1'b1, acc_m | f};
                12'b0010_00??_????: {wr, r} = {1'b1, f};
                12'b0010_10??_????, 12'b0011_11??_????: {wr, r} = {1'b1, f + 8'h01};
                12'h8??: {acc_m, pc_m, skip_m} = {w[7:0], stack_top_i, 1'b1};
                12'hc??: acc_m = w[7:0];
                12'hd??: {acc_m, z_m} = {acc_m | w[7:0], (acc_m | w[7:0]) == 8'h00};
                default: ;
            endcase
            if (wr)
            begin
                if (w[5])
                    rf[w[4:0]] = r;
                else
                    acc_m = r;
                // the skip form leaves the flag alone and drops the next word on a zero result instead
                if (w[11:6] == 6'h0f)
                    skip_m = (r == 8'h00);
                else
                    z_m = (r == 8'h00);
            end
        end
        @(posedge mclk_i);
        #2;
        dbg_addr_i = w[4:0];
        notes.push_back({pc_m, acc_m, z_m, rf[w[4:0]], bank_m, cfg_m, exp_m, pd_m, sl_m});
    endtask

    task automatic wake();
        instr_valid_i = 1'b0;
        wake_i = 1'b1;
        @(posedge mclk_i);
        #2;
        wake_i = 1'b0;
        sl_m = 1'b0;
    endtask

    always @(negedge mclk_i)
    begin
        if (notes.size() > 0)
            check(obs, notes.pop_front());
    end

    initial
    begin
        #(25 * 1500);
        num_errors++;
        results();
    end

    initial
    begin
        int k;
        void'($urandom(32'heb25a6f7));
        mreset();
        issue(OPC_NO_OP);
        // unassigned words must behave as no_operation
        issue(12'h001);
        issue(12'h040);
        $display("test reset done");
        issue(OPC_LOAD_LIT | 12'h0ff);
        issue(OPC_STORE_ACC | 12'h009);
        issue(OPC_INC_SKIP | 12'h029);
        issue(OPC_LOAD_LIT | 12'h055);
        issue(OPC_MOVE_FILE | 12'h029);
        issue(OPC_OR_LIT);
        issue(OPC_RETURN_LIT | 12'h0a5);
        issue(OPC_RETURN_LIT | 12'h03c);
        issue(OPC_LOAD_BANK | 12'h007);
        issue(OPC_OPTION);
        issue(OPC_LOAD_LIT);
        issue(OPC_OR_LIT);
        $display("test skip and return done");
        issue(OPC_SLEEP);
        issue(OPC_LOAD_LIT | 12'h011);
        issue(OPC_NO_OP);
        wake();
        issue(OPC_NO_OP);
        $display("test sleep done");
        repeat (200)
        begin
            k = $urandom_range(10);
            issue(bases[k] | (12'($urandom) & ~masks[k]));
        end
        $display("test random done");
        mreset();
        issue(OPC_NO_OP);
        instr_valid_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        $display("test second reset done");
        results();
    end
endmodule
